// File: rtl/sw_sysref_window_monitor.sv
// Sync-reference window monitor: capture, window flags, status registers
//
// Notes on behaviour
// - Reference captured on sampling clock falling edge.
// - Flag raised for edges within -60/+140 ps.
// - Windows one and two: lead far, centre.
// - Windows three to five: lag near, mid, far.
// - All window flags refresh on each reference rising edge.
// - Bit five is OR of window flags.
// - Seen flag sticky until clear bit or reset.
`timescale 1ns/1ps
module sw_sysref_window_monitor (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic sysref_pin_in,
	input wire logic [sw_pkg::NUM_TAPS-1:0] tap_pins_in,
	input wire logic [sw_pkg::ADDR_W-1:0] addr_in,
	input wire logic [sw_pkg::DATA_W-1:0] wr_data_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [sw_pkg::DATA_W-1:0] rd_data_out,
	output logic irq_out,
	output logic sync_seen_flag_out,
	output logic [sw_pkg::NUM_WIN-1:0] timing_window_flags_out
);
	import sw_pkg::*;

	typedef struct packed {
		logic [NUM_WIN-1:0] win;
		logic any_win;
		logic seen;
		logic enable;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic [DATA_W-1:0] edge_cnt;
		logic [DATA_W-1:0] rd_data;
		logic irq;
	} sw_mon_state_t;

	sw_mon_state_t st_reg;
	sw_mon_state_t st_next;

	logic sysref_sync;
	logic [NUM_TAPS-1:0] taps_sync;
	logic [DATA_W-1:0] status_word;
	logic [IRQ_W-1:0] irq_set;
	logic wr_clear;
	logic wr_irq_stat;

	sw_event_if ev ();

	sw_tap_sync #(.W(1)) u_ref_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.pin_in(sysref_pin_in),
		.sync_out(sysref_sync)
	);

	sw_tap_sync #(.W(NUM_TAPS)) u_tap_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.pin_in(tap_pins_in),
		.sync_out(taps_sync)
	);

	sw_window_decode u_decode (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.sysref_in(sysref_sync),
		.taps_in(taps_sync),
		.enable_in(st_reg.enable),
		.ev(ev)
	);

	always_comb begin
		status_word = '0;
		status_word[WIN_MSB:WIN_LSB] = st_reg.win;
		status_word[ANY_BIT] = st_reg.any_win;
		status_word[SEEN_BIT] = st_reg.seen;
	end

	always_comb begin
		wr_clear = wr_in && (addr_in == CLEAR_ADDR);
		wr_irq_stat = wr_in && (addr_in == IRQ_STAT_ADDR);
		irq_set = '0;
		if (ev.update) begin
			irq_set[IRQ_UPD_BIT] = 1'b1;
			irq_set[IRQ_SEEN_BIT] = !st_reg.seen;
			irq_set[IRQ_OFFCTR_BIT] = |(ev.flags & ~(5'h01 << CENTER_WIN));
		end
	end

	always_comb begin
		st_next = st_reg;
		st_next.rd_data = '0;

		// Software clear of the seen flag; a same-cycle detection wins
		if (wr_clear && wr_data_in[CLR_SEEN_BIT]) begin
			st_next.seen = 1'b0;
		end

		if (ev.update) begin
			st_next.win = ev.flags;
			st_next.any_win = |ev.flags;
			st_next.seen = 1'b1;
		end

		if (wr_in && addr_in == CTRL_ADDR) begin
			st_next.enable = wr_data_in[CTRL_EN_BIT];
		end
		if (wr_in && addr_in == IRQ_MASK_ADDR) begin
			st_next.irq_mask = wr_data_in[IRQ_W-1:0];
		end

		// Counter write clears it; an edge in the same cycle counts as one
		if (wr_in && addr_in == EDGE_CNT_ADDR) begin
			st_next.edge_cnt = ev.update ? 8'h01 : 8'h00;
		end else if (ev.update) begin
			st_next.edge_cnt = st_reg.edge_cnt + 8'h01;
		end

		// Write one to clear, new events win
		if (wr_irq_stat) begin
			st_next.irq_stat = st_reg.irq_stat & ~wr_data_in[IRQ_W-1:0];
		end
		st_next.irq_stat = st_next.irq_stat | irq_set;
		st_next.irq = |(st_next.irq_stat & st_next.irq_mask);

		if (rd_in) begin
			unique case (addr_in)
				STATUS_ADDR: st_next.rd_data = status_word;
				CLEAR_ADDR: st_next.rd_data = '0;
				CTRL_ADDR: st_next.rd_data = {7'h00, st_reg.enable};
				IRQ_STAT_ADDR: st_next.rd_data = {5'h00, st_reg.irq_stat};
				IRQ_MASK_ADDR: st_next.rd_data = {5'h00, st_reg.irq_mask};
				EDGE_CNT_ADDR: st_next.rd_data = st_reg.edge_cnt;
				default: st_next.rd_data = '0;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_reg <= '0;
			st_reg.enable <= CTRL_RESET[CTRL_EN_BIT];
			st_reg.irq_mask <= IRQ_MASK_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rd_data_out = st_reg.rd_data;
	assign irq_out = st_reg.irq;
	assign sync_seen_flag_out = st_reg.seen;
	assign timing_window_flags_out = st_reg.win;
endmodule

// File: rtl/sw_pkg.sv
// Constants shared by the sync-reference window monitor
package sw_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int NUM_WIN = 5;
	localparam int NUM_TAPS = NUM_WIN + 1;
	localparam int IRQ_W = 3;

	// Register addresses
	localparam logic [ADDR_W-1:0] CLEAR_ADDR = 12'h0102;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h0140;
	localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h0180;
	localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 12'h0181;
	localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 12'h0182;
	localparam logic [ADDR_W-1:0] EDGE_CNT_ADDR = 12'h0183;

	// Status register fields
	localparam int WIN_LSB = 0;
	localparam int WIN_MSB = 4;
	localparam int ANY_BIT = 5;
	localparam int SEEN_BIT = 6;
	localparam int CLR_SEEN_BIT = 6;
	localparam int CENTER_WIN = 1;

	// Control and interrupt fields
	localparam int CTRL_EN_BIT = 0;
	localparam logic [DATA_W-1:0] CTRL_RESET = 8'h01;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
	localparam int IRQ_UPD_BIT = 0;
	localparam int IRQ_SEEN_BIT = 1;
	localparam int IRQ_OFFCTR_BIT = 2;

	// Tap positions of the delay line relative to the capture point
	localparam int TAP_LEAD_PS = 60;
	localparam int TAP_STEP_PS = 40;
	localparam int TAP_LAG_PS = 140;
endpackage

// File: rtl/sw_event_if.sv
// Window result carrier between decoder and register block
`timescale 1ns/1ps
interface sw_event_if;
	logic update;
	logic [sw_pkg::NUM_WIN-1:0] flags;
	modport src (output update, flags);
	modport dst (input update, flags);
endinterface

// File: rtl/sw_tap_sync.sv
// Two-stage synchroniser, first stage on the falling clock edge
`timescale 1ns/1ps
module sw_tap_sync #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] fall_reg;

	// Capture point is the falling edge of the sampling clock
	always_ff @(negedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			fall_reg <= '0;
		end else begin
			fall_reg <= pin_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync_out <= '0;
		end else begin
			sync_out <= fall_reg;
		end
	end
endmodule

// File: rtl/sw_window_decode.sv
// Turns delay-line taps into window flags on each reference rising edge
`timescale 1ns/1ps
module sw_window_decode (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic sysref_in,
	input wire logic [sw_pkg::NUM_TAPS-1:0] taps_in,
	input wire logic enable_in,
	sw_event_if.src ev
);
	import sw_pkg::*;

	typedef struct packed {
		logic prev;
		logic update;
		logic [NUM_WIN-1:0] flags;
	} sw_dec_state_t;

	sw_dec_state_t st_reg;
	sw_dec_state_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.prev = sysref_in;
		st_next.update = 1'b0;
		if (enable_in && sysref_in && !st_reg.prev) begin
			st_next.update = 1'b1;
			for (int i = 0; i < NUM_WIN; i++) begin
				// A level change between neighbouring taps places the edge in window i
				st_next.flags[i] = taps_in[i] ^ taps_in[i+1];
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign ev.update = st_reg.update;
	assign ev.flags = st_reg.flags;
endmodule

// File: verification/sw_checker.sv
// Port assertions for the window monitor
`timescale 1ns/1ps
module sw_checker (
	input logic clk_in,
	input logic rst_in,
	input logic sysref_pin_in,
	input logic [5:0] tap_pins_in,
	input logic [11:0] addr_in,
	input logic wr_in,
	input logic rd_in,
	input logic [7:0] rd_data_out,
	input logic sync_seen_flag_out,
	input logic [4:0] timing_window_flags_out
);
	import sw_pkg::*;
	logic [4:0] w, f;
	logic s;
	assign w = tap_pins_in[4:0] ^ tap_pins_in[5:1];
	assign f = timing_window_flags_out;
	assign s = sync_seen_flag_out;
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	property p_cap; @(negedge clk_in) $rose(sysref_pin_in) |-> ##[1:6] s; endproperty
	a_cap: assert property (p_cap) else $error("seen late");
	property p_lead; $changed(f) |-> f[1:0] == $past(w[1:0], 2); endproperty
	a_lead: assert property (p_lead) else $error("lead");
	property p_lag; $changed(f) |-> f[4:2] == $past(w[4:2], 2); endproperty
	a_lag: assert property (p_lag) else $error("lag");
	property p_new; $changed(f) |-> $past(sysref_pin_in, 3); endproperty
	a_new: assert property (p_new) else $error("stray");
	property p_any; rd_in && addr_in == STATUS_ADDR |=> rd_data_out[5] == |$past(f); endproperty
	a_any: assert property (p_any) else $error("any");
	property p_clr; $fell(s) |-> $past(wr_in) || $past(wr_in, 2); endproperty
	a_clr: assert property (p_clr) else $error("clear");
	property p_set; $rose(s) |-> $past(sysref_pin_in, 3); endproperty
	a_set: assert property (p_set) else $error("set");
	property p_rst; $fell(rst_in) |-> !s && f == 5'h00 && rd_data_out == 8'h00; endproperty
	a_rst: assert property (p_rst) else $error("reset");
	c_set: cover property ($rose(s));
	c_mid: cover property (f == 5'h02);
	c_clr: cover property ($fell(s));
endmodule
bind sw_sysref_window_monitor sw_checker chk_u (.*);

// File: verification/sw_sysref_src.sv
// Sync reference source: pin and delay-line taps
`timescale 1ns/1ps
module sw_sysref_src (
	input logic clk_in,
	output logic pin_out,
	output logic [5:0] taps_out
);
	initial {pin_out, taps_out} = '0;
	task automatic pulse(input logic [5:0] t);
		@(posedge clk_in);
		{pin_out, taps_out} <= {1'b1, t};
		repeat (10) @(posedge clk_in);
		{pin_out, taps_out} <= '0;
		repeat (10) @(posedge clk_in);
	endtask
endmodule

// File: verification/test_sysref_window_monitor.sv
// Bench for the sync reference window monitor
`timescale 1ns/1ps
module test_sysref_window_monitor;
	import sw_pkg::*;
	logic clk_in = '0, rst_in = '1, wr_in = '0, rd_in = '0;
	logic sysref_pin_in, irq_out, sync_seen_flag_out;
	logic [11:0] addr_in = '0;
	logic [7:0] wr_data_in = '0, rd_data_out;
	logic [5:0] tap_pins_in, t;
	logic [4:0] timing_window_flags_out, w;
	int error_cnt = 0, num_checks = 0, cyc = 0;
	always #2.5 clk_in = ~clk_in;
	sw_sysref_src src_u (.clk_in, .pin_out(sysref_pin_in), .taps_out(tap_pins_in));
	sw_sysref_window_monitor dut_u (.*);
	task automatic check(input logic [7:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %0t %h %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic acc(input logic we, input logic [11:0] a, input logic [7:0] v);
		@(posedge clk_in);
		addr_in <= a;
		wr_data_in <= v;
		wr_in <= we;
		rd_in <= !we;
		@(posedge clk_in);
		{wr_in, rd_in} <= 2'h0;
		// Read data stand only until the next rising edge: look mid-cycle
		@(negedge clk_in);
		if (!we) check(rd_data_out, v);
	endtask
	function automatic logic [4:0] win(input logic [5:0] x);
		return x[4:0] ^ x[5:1];
	endfunction
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			summarize();
		end
	end
	initial begin
		void'($urandom(667));
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
		acc(0, STATUS_ADDR, 8'h00);
		acc(0, 12'hfff, 8'h00);
		for (int i = 0; i < 6; i++) begin
			t = i == 1 ? 6'h00 : i == 2 ? 6'h3c : 6'($urandom);
			w = win(t);
			src_u.pulse(t);
			check({3'h0, timing_window_flags_out}, {3'h0, w});
			acc(0, STATUS_ADDR, {2'h1, |w, w});
		end
		acc(0, EDGE_CNT_ADDR, 8'h06);
		acc(1, CLEAR_ADDR, 8'h40);
		acc(0, STATUS_ADDR, {2'h0, |w, w});
		acc(1, IRQ_STAT_ADDR, 8'h07);
		acc(1, IRQ_MASK_ADDR, 8'h02);
		src_u.pulse(6'h3f);
		check({7'h0, irq_out}, 8'h01);
		acc(1, IRQ_STAT_ADDR, 8'h02);
		@(posedge clk_in);
		check({7'h0, irq_out}, 8'h00);
		acc(0, IRQ_STAT_ADDR, 8'h01);
		// Edges while the monitor is disabled leave count and flags alone
		acc(1, CTRL_ADDR, 8'h00);
		acc(0, CTRL_ADDR, 8'h00);
		src_u.pulse(6'h01);
		acc(0, EDGE_CNT_ADDR, 8'h07);
		acc(0, STATUS_ADDR, 8'h40);
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		acc(0, STATUS_ADDR, 8'h00);
		summarize();
	end
endmodule
